// ===== logic/issp_pkg.sv
// Package with shared constants and carrier types for the input state serializer
package issp_pkg;

  // Channel count and frame lengths
  localparam int ISSP_CHANNELS = 8;
  localparam int ISSP_FRAME_LONG = 16;
  localparam int ISSP_FRAME_SHORT = 8;
  localparam logic [4:0] ISSP_LEN_LONG = 5'h10;
  localparam logic [4:0] ISSP_LEN_SHORT = 5'h08;

  // Filter divider ratios
  localparam int ISSP_DIV_LOW = 8;
  localparam int ISSP_DIV_HIGH = 64;
  localparam logic [6:0] ISSP_DIV_LOW_LAST = 7'h07;
  localparam logic [6:0] ISSP_DIV_HIGH_LAST = 7'h3f;

  // Oscillator tick prescale from core clock (cycles per oscillator period)
  localparam int ISSP_OSC_PRESCALE = 50;

  // Stop bits of the long frame
  localparam logic ISSP_STOP_LOW = 1'b0;
  localparam logic ISSP_STOP_HIGH = 1'b1;

  // Reset value of the filtered input states
  localparam logic [7:0] ISSP_STATE_RESET = 8'h00;

  // Synchronised serial pins
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic mosi;
  } issp_spi_t;

  // Serial output pin pair with enables
  typedef struct packed {
    logic data;
    logic data_inv;
    logic oe;
  } issp_out_t;

endpackage

// ===== logic/issp_filter.sv
// Two-stage sampling filter for all input channels with its tick divider
`timescale 1ns/100ps
module issp_filter
  import issp_pkg::*;
#(
  parameter int CHANNELS = ISSP_CHANNELS,
  parameter int OSC_PRESCALE = ISSP_OSC_PRESCALE
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // Configuration
  input wire logic filter_divider_select_in,
  // Raw comparator states, already synchronised
  input wire logic [CHANNELS-1:0] raw_in,
  // Filtered states
  output logic [CHANNELS-1:0] state_out
);

  logic [15:0] osc_cnt;
  logic [15:0] next_osc_cnt;
  logic [6:0] div_cnt;
  logic [6:0] next_div_cnt;
  logic filter_sample_clock;
  logic [6:0] div_last;
  logic [CHANNELS-1:0] stage1;
  logic [CHANNELS-1:0] stage2;
  logic [CHANNELS-1:0] next_stage1;
  logic [CHANNELS-1:0] next_stage2;
  logic [CHANNELS-1:0] held;
  logic [CHANNELS-1:0] next_held;

  // Oscillator tick and divider produce one-cycle sample enables
  always_comb begin
    div_last = filter_divider_select_in ? ISSP_DIV_HIGH_LAST : ISSP_DIV_LOW_LAST; // RULE11
    next_osc_cnt = osc_cnt + 16'h0001;
    next_div_cnt = div_cnt;
    filter_sample_clock = 1'b0;
    if (osc_cnt == 16'(OSC_PRESCALE - 1)) begin
      next_osc_cnt = 16'h0000;
      if (div_cnt >= div_last) begin
        next_div_cnt = 7'h00;
        filter_sample_clock = 1'b1;
      end else begin
        next_div_cnt = div_cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      osc_cnt <= 16'h0000;
      div_cnt <= 7'h00;
    end else begin
      osc_cnt <= next_osc_cnt;
      div_cnt <= next_div_cnt;
    end
  end

  // Two sampling steps per channel; the held state follows only when both
  // steps agree, so a change needs two to three ticks and a blip shorter
  // than one tick never reaches the output
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_chan
      always_comb begin
        next_stage1[g] = stage1[g];
        next_stage2[g] = stage2[g];
        next_held[g] = held[g];
        if (filter_sample_clock) begin
          next_stage1[g] = raw_in[g]; // RULE9
          next_stage2[g] = stage1[g]; // RULE9
          if (stage1[g] == stage2[g]) begin
            next_held[g] = stage2[g]; // RULE10
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      stage1 <= ISSP_STATE_RESET;
      stage2 <= ISSP_STATE_RESET;
      held <= ISSP_STATE_RESET;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
      held <= next_held;
    end
  end

  assign state_out = held;

endmodule

// ===== logic/issp_top.sv
// Input state serializer: filtered inputs shifted out over a mode 0 SPI target
`timescale 1ns/100ps
// What this block does
// [RULE1] Master frames with chip select, mode 0
// [RULE2] Load states on select fall, end on rise
// [RULE3] First bit driven as select falls
// [RULE4] Sample serial input on rising clock
// [RULE5] Shift on falling clock, MSB first
// [RULE6] Serial input enters MSB first
// [RULE7] Static input picks 8 or 16 bits
// [RULE8] Low picks 16, high picks 8
// [RULE9] Two-stage filter per input channel
// [RULE10] Filter delay two to three ticks
// [RULE11] Tick is oscillator times 8 or 64
// [RULE12] Long frame: inputs, control, stop bit
// [RULE13] Fixed bit map of the long frame
// [RULE14] Master receiver holds sixteen bits
// [RULE15] Supply alarm low while supply low
// [RULE16] Heat alarm low while too hot
// [RULE17] Four XNOR parity bits at 5..2
// [RULE18] Parity groups fixed and documented
// [RULE19] Supply loss holds output low
// [RULE20] Master checks last stop bit
// [RULE21] Power-loss reset from either supply
// [RULE22] Outputs released while select high
// [RULE23] Inverted output complements data output
// [RULE24] Short frame carries inputs only
module issp_top
  import issp_pkg::*;
#(
  parameter int OSC_PRESCALE = ISSP_OSC_PRESCALE
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // Serial pins from the master
  input wire logic spi_cs_n_in,
  input wire logic spi_sclk_in,
  input wire logic spi_mosi_in,
  // Serial output pins with enables
  output logic spi_miso_out,
  output logic spi_miso_n_out,
  output logic spi_miso_oe_out,
  // Static straps
  input wire logic frame_length_select_in,
  input wire logic filter_divider_select_in,
  // Raw channel comparators
  input wire logic [ISSP_CHANNELS-1:0] channel_in,
  // Monitors
  input wire logic supply_low_monitor_in,
  input wire logic overheat_monitor_in,
  input wire logic field_supply_fail_in,
  input wire logic logic_supply_fail_in,
  // Received word from the master
  output logic [ISSP_FRAME_LONG-1:0] rx_word_out,
  output logic rx_valid_out
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] pin_meta;
  issp_spi_t pin_sync;
  logic [ISSP_CHANNELS-1:0] chan_meta;
  logic [ISSP_CHANNELS-1:0] chan_sync;
  logic [5:0] mon_meta;
  logic [5:0] mon_sync;

  // Two flip-flops on every asynchronous input. Every pin edge is seen three
  // cycles late, so the master keeps the serial clock high and low for at
  // least four cycles; select, clock and data share the same delay, which
  // keeps their relative timing intact.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pin_meta <= 3'h4; // Idle levels, so no false clock edge follows reset
      pin_sync <= '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
      chan_meta <= ISSP_STATE_RESET;
      chan_sync <= ISSP_STATE_RESET;
      mon_meta <= 6'h00;
      mon_sync <= 6'h00;
    end else begin
      pin_meta <= {spi_cs_n_in, spi_sclk_in, spi_mosi_in};
      pin_sync <= pin_meta;
      chan_meta <= channel_in;
      chan_sync <= chan_meta;
      mon_meta <= {frame_length_select_in, filter_divider_select_in,
                   supply_low_monitor_in, overheat_monitor_in,
                   field_supply_fail_in, logic_supply_fail_in};
      mon_sync <= mon_meta;
    end
  end

  logic short_mode;
  logic div_high;
  logic supply_low;
  logic overheat;
  logic power_loss_n;

  // Power-loss reset is active low when either supply has dropped.
  // The frame still runs under loss, so the master sees a low stop bit.
  always_comb begin
    short_mode = mon_sync[5]; // RULE8
    div_high = mon_sync[4];
    supply_low = mon_sync[3];
    overheat = mon_sync[2];
    power_loss_n = ~(mon_sync[1] | mon_sync[0]); // RULE21
  end

  // ----------------------------------------
  // Input filter
  // ----------------------------------------
  logic [ISSP_CHANNELS-1:0] filt_state;

  // Filter runs from the core clock through one-cycle tick enables
  issp_filter #(
    .CHANNELS(ISSP_CHANNELS),
    .OSC_PRESCALE(OSC_PRESCALE)
  ) u_filter (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .filter_divider_select_in(div_high),
    .raw_in(chan_sync),
    .state_out(filt_state)
  );

  // ----------------------------------------
  // Frame assembly
  // ----------------------------------------
  logic supply_low_alarm_n;
  logic overheat_alarm_n;
  logic parity_check_bit_1;
  logic parity_check_bit_2;
  logic parity_check_bit_3;
  logic parity_check_bit_4;
  logic [ISSP_FRAME_LONG-1:0] frame_word;

  // Alarms and XNOR parity groups over data and alarm bits.
  // Groups the master checks against (inN is filtered input N):
  //   parity_check_bit_1 = XNOR of in8, in7 and supply_low_alarm_n
  //   parity_check_bit_2 = XNOR of in6, in5 and overheat_alarm_n
  //   parity_check_bit_3 = XNOR of in4, in3 and supply_low_alarm_n
  //   parity_check_bit_4 = XNOR of in2, in1 and overheat_alarm_n
  // Each alarm sits in two groups, so a flipped alarm bit shows twice.
  always_comb begin
    supply_low_alarm_n = ~supply_low; // RULE15
    overheat_alarm_n = ~overheat; // RULE16
    parity_check_bit_1 = ~(^{filt_state[7:6], supply_low_alarm_n}); // RULE17 RULE18
    parity_check_bit_2 = ~(^{filt_state[5:4], overheat_alarm_n}); // RULE18
    parity_check_bit_3 = ~(^{filt_state[3:2], supply_low_alarm_n}); // RULE18
    parity_check_bit_4 = ~(^{filt_state[1:0], overheat_alarm_n}); // RULE18
    frame_word = {filt_state, supply_low_alarm_n, overheat_alarm_n,
                  parity_check_bit_1, parity_check_bit_2,
                  parity_check_bit_3, parity_check_bit_4,
                  ISSP_STOP_LOW, ISSP_STOP_HIGH}; // RULE12 RULE13
  end

  // ----------------------------------------
  // Serial engine
  // ----------------------------------------
  typedef enum logic [0:0] {
    ISSP_IDLE = 1'b0,
    ISSP_XFER = 1'b1
  } issp_state_t;

  issp_state_t state;
  issp_state_t next_state;
  logic [ISSP_FRAME_LONG-1:0] shift;
  logic [ISSP_FRAME_LONG-1:0] next_shift;
  logic [ISSP_FRAME_LONG-1:0] rx_shift;
  logic [ISSP_FRAME_LONG-1:0] next_rx_shift;
  logic sampled;
  logic next_sampled;
  logic [4:0] bit_cnt;
  logic [4:0] next_bit_cnt;
  logic [4:0] frame_len;
  logic [ISSP_FRAME_LONG-1:0] next_rx_word;
  logic next_rx_valid;
  logic sclk_prev;
  logic cs_prev;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;

  // Edge detection on the synchronised pins; the previous-value flops
  // reset to the idle levels of their pins
  always_comb begin
    sclk_rise = pin_sync.sclk & ~sclk_prev;
    sclk_fall = ~pin_sync.sclk & sclk_prev;
    cs_fall = ~pin_sync.cs_n & cs_prev;
    cs_rise = pin_sync.cs_n & ~cs_prev;
    frame_len = short_mode ? ISSP_LEN_SHORT : ISSP_LEN_LONG; // RULE7
  end

  // Load on select fall, sample on rising clock, shift on falling clock.
  // The received bit waits in sampled until the following fall, so the
  // receive word moves in step with the transmit word. Falls beyond the
  // frame length are ignored and the output then shows zeros.
  always_comb begin
    next_state = state;
    next_shift = shift;
    next_rx_shift = rx_shift;
    next_sampled = sampled;
    next_bit_cnt = bit_cnt;
    next_rx_word = rx_word_out;
    next_rx_valid = 1'b0;
    case (state)
      ISSP_IDLE: begin
        if (cs_fall) begin
          next_state = ISSP_XFER;
          next_bit_cnt = 5'h00;
          next_rx_shift = '0;
          if (short_mode) begin
            next_shift = {filt_state, 8'h00}; // RULE24
          end else begin
            next_shift = frame_word; // RULE2
          end
        end
      end
      ISSP_XFER: begin
        if (cs_rise) begin
          next_state = ISSP_IDLE; // RULE2
          next_rx_word = rx_shift;
          next_rx_valid = 1'b1;
        end else begin
          if (sclk_rise) begin
            next_sampled = pin_sync.mosi; // RULE4
          end
          if (sclk_fall && bit_cnt < frame_len) begin
            next_shift = {shift[ISSP_FRAME_LONG-2:0], 1'b0}; // RULE5
            next_rx_shift = {rx_shift[ISSP_FRAME_LONG-2:0], sampled}; // RULE6
            next_bit_cnt = bit_cnt + 5'h01;
          end
        end
      end
      default: begin
        next_state = ISSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state <= ISSP_IDLE;
      shift <= '0;
      rx_shift <= '0;
      sampled <= 1'b0;
      bit_cnt <= 5'h00;
      rx_word_out <= '0;
      rx_valid_out <= 1'b0;
      sclk_prev <= 1'b0;
      cs_prev <= 1'b1;
    end else begin
      state <= next_state;
      shift <= next_shift;
      rx_shift <= next_rx_shift;
      sampled <= next_sampled;
      bit_cnt <= next_bit_cnt;
      rx_word_out <= next_rx_word;
      rx_valid_out <= next_rx_valid;
      sclk_prev <= pin_sync.sclk;
      cs_prev <= pin_sync.cs_n;
    end
  end

  // ----------------------------------------
  // Output pins
  // ----------------------------------------
  issp_out_t pin_out;
  issp_out_t next_pin_out;
  logic data_bit;

  // First bit is ready before select is seen low; loss forces low.
  // The pin pair and its enable change together on one edge, so the
  // data never shows a half-updated value while the enable is high.
  always_comb begin
    if (state == ISSP_XFER) begin
      data_bit = shift[ISSP_FRAME_LONG-1];
    end else begin
      data_bit = short_mode ? filt_state[7] : frame_word[ISSP_FRAME_LONG-1]; // RULE3
    end
    next_pin_out.data = data_bit & power_loss_n; // RULE19
    next_pin_out.data_inv = ~next_pin_out.data; // RULE23
    next_pin_out.oe = ~pin_sync.cs_n; // RULE22
  end

  // Output register; in reset the data is low and its complement high
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pin_out <= '{data: 1'b0, data_inv: 1'b1, oe: 1'b0};
    end else begin
      pin_out <= next_pin_out;
    end
  end

  assign spi_miso_out = pin_out.data;
  assign spi_miso_n_out = pin_out.data_inv;
  assign spi_miso_oe_out = pin_out.oe;

endmodule

// ===== tb/issp_monitor.sv
// Checker of serial pin timing for the input state serializer
`timescale 1ns/100ps
module issp_monitor (
  // Observed ports
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sclk_in,
  input wire logic spi_miso_out,
  input wire logic spi_miso_n_out,
  input wire logic spi_miso_oe_out,
  input wire logic field_supply_fail_in,
  input wire logic logic_supply_fail_in,
  input wire logic rx_valid_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  // Both supplies healthy
  wire good = !field_supply_fail_in && !logic_supply_fail_in;
  // ----------------------------------------
  // Pin relations
  // ----------------------------------------
  a_pins_complement: assert property (spi_miso_oe_out |-> spi_miso_n_out == !spi_miso_out)
    else $error("miso_n not inverse of miso");
  a_select_drives: assert property ((!spi_cs_n_in)[*4] |-> spi_miso_oe_out)
    else $error("outputs not driven in frame");
  a_select_release: assert property (spi_cs_n_in[*4] |-> !spi_miso_oe_out)
    else $error("outputs driven while deselected");
  a_loss_low: assert property ((spi_miso_oe_out && !good)[*4] |-> !spi_miso_out)
    else $error("miso high under power loss");
  a_first_held: assert property ($rose(spi_miso_oe_out) && good |=> $stable(spi_miso_out))
    else $error("first bit not held");
  a_shift_fall: assert property ((spi_sclk_in && spi_miso_oe_out && good)[*2] |-> $stable(spi_miso_out))
    else $error("miso moved while clock high");
  a_end_valid: assert property ($rose(spi_cs_n_in) |-> ##[2:5] rx_valid_out)
    else $error("no valid after frame end");
  a_valid_pulse: assert property (rx_valid_out |=> !rx_valid_out)
    else $error("valid longer than one cycle");
endmodule
bind issp_top issp_monitor issp_monitor_inst (.core_clk_in(core_clk_in), .srst_in(srst_in),
  .spi_cs_n_in(spi_cs_n_in), .spi_sclk_in(spi_sclk_in), .spi_miso_out(spi_miso_out),
  .spi_miso_n_out(spi_miso_n_out), .spi_miso_oe_out(spi_miso_oe_out),
  .field_supply_fail_in(field_supply_fail_in), .logic_supply_fail_in(logic_supply_fail_in),
  .rx_valid_out(rx_valid_out));

// ===== tb/issp_spi_master.sv
// Mode 0 serial master model for the serializer pins
`timescale 1ns/100ps
module issp_spi_master (
  // Clock
  input wire logic core_clk_in,
  // Serial pins
  output logic cs_n_out,
  output logic sclk_out,
  output logic mosi_out,
  input wire logic miso_in
);
  localparam int HALF = 5;
  // Idle pins, clock parked low
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b0;
  end
  // ----------------------------------------
  // One frame of n clocks, MSB first both ways
  // ----------------------------------------
  task automatic xfer(input int n, input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge core_clk_in) #1 cs_n_out = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi_out = tx[i];
      repeat (HALF) @(posedge core_clk_in);
      #1 rx = {rx[14:0], miso_in};
      sclk_out = 1'b1;
      repeat (HALF) @(posedge core_clk_in);
      #1 sclk_out = 1'b0;
    end
    repeat (HALF) @(posedge core_clk_in);
    #1 cs_n_out = 1'b1;
    mosi_out = ~mosi_out; // Stale data is not left on the line
  endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the input state serializer
`timescale 1ns/100ps
module testbench import issp_pkg::*;;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic fls = 1'b0;
  logic dvs = 1'b0;
  logic uv = 1'b0;
  logic ot = 1'b0;
  logic ff = 1'b0;
  logic lf = 1'b0;
  logic [7:0] ch = 8'h00;
  logic [7:0] old;
  logic cs_n, sclk, mosi, miso, miso_n, oe, rxv;
  logic [15:0] rxw, rx;
  wire miso_line = oe ? miso : 1'bz;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #10 core_clk_in = ~core_clk_in;
  issp_top #(.OSC_PRESCALE(2)) issp_top_inst (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .spi_cs_n_in(cs_n), .spi_sclk_in(sclk), .spi_mosi_in(mosi), .spi_miso_out(miso),
    .spi_miso_n_out(miso_n), .spi_miso_oe_out(oe), .frame_length_select_in(fls),
    .filter_divider_select_in(dvs), .channel_in(ch), .supply_low_monitor_in(uv),
    .overheat_monitor_in(ot), .field_supply_fail_in(ff), .logic_supply_fail_in(lf),
    .rx_word_out(rxw), .rx_valid_out(rxv));
  issp_spi_master issp_spi_master_inst (.core_clk_in(core_clk_in), .cs_n_out(cs_n),
    .sclk_out(sclk), .mosi_out(mosi), .miso_in(miso_line));
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Cycle ceiling against a hang
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      final_report();
    end
  end
  // Expected frame as seen by the master
  function automatic logic [15:0] exp_frame(logic [7:0] s, logic u, logic o, logic sh, logic ls);
    logic un;
    logic on;
    un = ~u;
    on = ~o;
    if (ls) return 16'h0000;
    if (sh) return {8'h00, s};
    return {s, un, on, ~^{s[7], s[6], un}, ~^{s[5], s[4], on}, ~^{s[3], s[2], un},
      ~^{s[1], s[0], on}, ISSP_STOP_LOW, ISSP_STOP_HIGH};
  endfunction
  // One frame with its received word and end pulse
  task automatic frame(input int n, input logic [7:0] s, input string what);
    logic [15:0] tx;
    logic [15:0] e;
    int k;
    tx = 16'($urandom);
    e = exp_frame(s, uv, ot, fls, ff | lf);
    issp_spi_master_inst.xfer(n, tx, rx);
    if (n == 16 && fls) e = {e[7:0], 8'h00};
    check({what, " miso"}, rx, e);
    k = 0;
    while (k < 12 && rxv !== 1'b1) begin
      @(posedge core_clk_in);
      #1 k++;
    end
    check({what, " valid"}, {15'h0000, rxv}, 16'h0001);
    if (!(ff | lf) && n == (fls ? 8 : 16)) begin
      check({what, " word"}, fls ? {8'h00, rxw[7:0]} : rxw, fls ? {8'h00, tx[7:0]} : tx);
    end
    $display("done %s", what);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h3e2c));
    repeat (8) @(posedge core_clk_in);
    #1 srst_in = 1'b0;
    for (int i = 0; i < 24; i++) begin
      ch = 8'($urandom);
      uv = 1'($urandom);
      ot = 1'($urandom);
      fls = 1'($urandom);
      repeat (80) @(posedge core_clk_in);
      #1 frame(fls ? 8 : 16, ch, "random");
    end
    fls = 1'b1;
    repeat (10) @(posedge core_clk_in);
    #1 frame(16, ch, "overlong");
    fls = 1'b0;
    for (int d = 0; d < 2; d++) begin
      dvs = d[0];
      repeat (800) @(posedge core_clk_in);
      #1 old = ch;
      ch = ~ch;
      repeat (d ? 200 : 20) @(posedge core_clk_in);
      #1 frame(16, old, "filter early");
      repeat (d ? 300 : 60) @(posedge core_clk_in);
      #1 frame(16, ch, "filter late");
    end
    ff = 1'b1;
    repeat (10) @(posedge core_clk_in);
    #1 frame(16, ch, "field loss");
    ff = 1'b0;
    lf = 1'b1;
    repeat (10) @(posedge core_clk_in);
    #1 frame(16, ch, "logic loss");
    final_report();
  end
endmodule
